// ### design/gfm_pkg.sv
package gfm_pkg;

  // ***************************************************************
  // Bank sizes
  // ***************************************************************
  localparam int USER_PINS = 30;
  localparam int FLASH_PINS = 6;
  localparam int ALL_PINS = 36;
  localparam int FLASH_BASE = 30;
  localparam int FUNCTION_SELECTOR_W = 5;

  // ***************************************************************
  // Function select codes
  // ***************************************************************
  localparam logic [4:0] FN_FLASH = 5'h00;
  localparam logic [4:0] FN_SPI = 5'h01;
  localparam logic [4:0] FN_UART = 5'h02;
  localparam logic [4:0] FN_I2C = 5'h03;
  localparam logic [4:0] FN_PWM = 5'h04;
  localparam logic [4:0] FN_SOFT_IO = 5'h05;
  localparam logic [4:0] FN_PROG_A = 5'h06;
  localparam logic [4:0] FN_PROG_B = 5'h07;
  localparam logic [4:0] FN_CLOCK = 5'h08;
  localparam logic [4:0] FN_USB = 5'h09;

  // ***************************************************************
  // Override modes for output, enable and input paths
  // ***************************************************************
  localparam logic [1:0] OVR_NORMAL = 2'h0;
  localparam logic [1:0] OVR_INVERT = 2'h1;
  localparam logic [1:0] OVR_LOW = 2'h2;
  localparam logic [1:0] OVR_HIGH = 2'h3;

  // ***************************************************************
  // Fixed pin placements
  // ***************************************************************
  localparam int CLKIN0_PIN = 20;
  localparam int CLKIN1_PIN = 22;
  localparam int USB_OVCUR_SEL = 0;
  localparam int USB_VBUS_DET_SEL = 1;
  localparam int USB_VBUS_EN_SEL = 2;

  function automatic int spi_unit(input int n);
    return (n >> 3) & 1;
  endfunction : spi_unit

  function automatic int uart_unit(input int n);
    return ((n + 4) >> 3) & 1;
  endfunction : uart_unit

  function automatic int i2c_unit(input int n);
    return (n >> 1) & 1;
  endfunction : i2c_unit

  function automatic int role4(input int n);
    return n & 3;
  endfunction : role4

  function automatic int pwm_slice(input int n);
    return (n >> 1) & 7;
  endfunction : pwm_slice

  function automatic int usb_sel(input int n);
    return n % 3;
  endfunction : usb_sel

  // Clock output index on a pin, or -1 where the pin has none.
  function automatic int gpout_index(input int n);
    case (n)
      21: return 0;
      23: return 1;
      24: return 2;
      25: return 3;
      default: return -1;
    endcase
  endfunction : gpout_index

  function automatic logic ovr(input logic v, input logic [1:0] m);
    case (m)
      OVR_INVERT: return ~v;
      OVR_LOW: return 1'b0;
      OVR_HIGH: return 1'b1;
      default: return v;
    endcase
  endfunction : ovr

endpackage : gfm_pkg

// ### design/gfm_mux.sv
`timescale 1ns/1ns
module gfm_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pads: 29..0 user bank, 35..30 flash sck, csn, data 0..3
  input wire logic [35:0] pad_in,
  output logic [35:0] pad_out,
  output logic [35:0] pad_oe,
  // Per-pin control
  input wire logic [29:0][4:0] function_select_field_user,
  input wire logic [5:0][4:0] function_select_field_flash,
  input wire logic [35:0][1:0] out_override,
  input wire logic [35:0][1:0] oe_override,
  input wire logic [35:0][1:0] in_override,
  // Single-cycle software IO
  input wire logic [35:0] soft_io_out,
  input wire logic [35:0] soft_io_oe,
  output logic [35:0] soft_io_in,
  // Programmable IO blocks
  input wire logic [29:0] prog_a_out,
  input wire logic [29:0] prog_a_oe,
  input wire logic [29:0] prog_b_out,
  input wire logic [29:0] prog_b_oe,
  output logic [29:0] prog_in,
  // Serial peripherals, [unit][role]
  input wire logic [1:0][3:0] spi_out,
  input wire logic [1:0][3:0] spi_oe,
  output logic [1:0][3:0] spi_in,
  input wire logic [1:0][3:0] uart_out,
  input wire logic [1:0][3:0] uart_oe,
  output logic [1:0][3:0] uart_in,
  input wire logic [1:0][1:0] i2c_out,
  input wire logic [1:0][1:0] i2c_oe,
  output logic [1:0][1:0] i2c_in,
  // PWM slices, [slice][channel]
  input wire logic [7:0][1:0] pwm_out,
  input wire logic [7:0][1:0] pwm_oe,
  output logic [7:0] pwm_b_in,
  // Clocks
  input wire logic [3:0] general_clock_output,
  output logic [1:0] external_clock_input,
  // USB power
  output logic usb_overcurrent_detect,
  output logic usb_vbus_detect,
  input wire logic usb_vbus_enable,
  // Flash interface
  input wire logic [5:0] flash_execute_in_place_out,
  input wire logic [5:0] flash_execute_in_place_oe,
  output logic [5:0] flash_execute_in_place_in
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [35:0] sync1;
    logic [35:0] sync2;
    logic [35:0] sync3;
    logic [35:0] level;
    logic [35:0] pad_out;
    logic [35:0] pad_oe;
    logic [35:0] soft_io_in;
    logic [29:0] prog_in;
    logic [1:0][3:0] spi_in;
    logic [1:0][3:0] uart_in;
    logic [1:0][1:0] i2c_in;
    logic [7:0] pwm_b_in;
    logic [1:0] clk_in;
    logic usb_ovcur;
    logic usb_vbus_det;
    logic [5:0] flash_in;
  } gfm_state_t;

  gfm_state_t st;
  gfm_state_t next_st;
  logic [35:0] lvl;
  logic [35:0] mux_out;
  logic [35:0] mux_oe;

  // ***************************************************************
  // Per-pin output selection
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < gfm_pkg::ALL_PINS; g++) begin : g_pin
      localparam int GO = gfm_pkg::gpout_index(g);
      localparam int GI = (GO < 0) ? 0 : GO;
      logic mo;
      logic me;
      assign lvl[g] = gfm_pkg::ovr(st.level[g], in_override[g]);
      if (g < gfm_pkg::USER_PINS) begin : g_user
        localparam int RL = gfm_pkg::role4(g);
        localparam int SU = gfm_pkg::spi_unit(g);
        localparam int UU = gfm_pkg::uart_unit(g);
        localparam int IU = gfm_pkg::i2c_unit(g);
        localparam int PS = gfm_pkg::pwm_slice(g);
        localparam int CH = g & 1;
        localparam int US = gfm_pkg::usb_sel(g);
        always_comb begin
          // Anything not listed below leaves the pad undriven.
          mo = 1'b0;
          me = 1'b0;
          case (function_select_field_user[g])
            gfm_pkg::FN_SPI: begin
              mo = spi_out[SU][RL];
              me = spi_oe[SU][RL];
            end
            gfm_pkg::FN_UART: begin
              mo = uart_out[UU][RL];
              me = uart_oe[UU][RL];
            end
            gfm_pkg::FN_I2C: begin
              mo = i2c_out[IU][CH];
              me = i2c_oe[IU][CH];
            end
            gfm_pkg::FN_PWM: begin
              mo = pwm_out[PS][CH];
              me = pwm_oe[PS][CH];
            end
            gfm_pkg::FN_SOFT_IO: begin
              mo = soft_io_out[g];
              me = soft_io_oe[g];
            end
            gfm_pkg::FN_PROG_A: begin
              mo = prog_a_out[g];
              me = prog_a_oe[g];
            end
            gfm_pkg::FN_PROG_B: begin
              mo = prog_b_out[g];
              me = prog_b_oe[g];
            end
            gfm_pkg::FN_CLOCK: begin
              if (GO >= 0) begin
                mo = general_clock_output[GI];
                me = 1'b1;
              end
            end
            gfm_pkg::FN_USB: begin
              if (US == gfm_pkg::USB_VBUS_EN_SEL) begin
                mo = usb_vbus_enable;
                me = 1'b1;
              end
            end
            default: begin
              mo = 1'b0;
              me = 1'b0;
            end
          endcase
        end
      end else begin : g_flash
        localparam int FI = g - gfm_pkg::FLASH_BASE;
        always_comb begin
          mo = 1'b0;
          me = 1'b0;
          case (function_select_field_flash[FI])
            gfm_pkg::FN_FLASH: begin
              mo = flash_execute_in_place_out[FI];
              me = flash_execute_in_place_oe[FI];
            end
            gfm_pkg::FN_SOFT_IO: begin
              mo = soft_io_out[g];
              me = soft_io_oe[g];
            end
            default: begin
              mo = 1'b0;
              me = 1'b0;
            end
          endcase
        end
      end
      assign mux_out[g] = mo;
      assign mux_oe[g] = me;
    end
  endgenerate

  // ***************************************************************
  // Next state: input sync, input routing, output overrides
  // ***************************************************************
  always_comb begin
    next_st = st;
    // Three-stage sync; the level moves only when the last two agree.
    next_st.sync1 = pad_in;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int p = 0; p < gfm_pkg::ALL_PINS; p++) begin
      if (st.sync2[p] == st.sync3[p]) begin
        next_st.level[p] = st.sync3[p];
      end
      next_st.pad_out[p] = gfm_pkg::ovr(mux_out[p], out_override[p]);
      next_st.pad_oe[p] = gfm_pkg::ovr(mux_oe[p], oe_override[p]);
    end
    next_st.soft_io_in = lvl;
    next_st.prog_in = lvl[gfm_pkg::USER_PINS-1:0];
    // Unmapped peripheral inputs read low, the identity of the OR.
    next_st.spi_in = '0;
    next_st.uart_in = '0;
    next_st.i2c_in = '0;
    next_st.pwm_b_in = '0;
    next_st.clk_in = '0;
    next_st.usb_ovcur = 1'b0;
    next_st.usb_vbus_det = 1'b0;
    next_st.flash_in = '0;
    for (int n = 0; n < gfm_pkg::USER_PINS; n++) begin
      case (function_select_field_user[n])
        gfm_pkg::FN_SPI: begin
          next_st.spi_in[gfm_pkg::spi_unit(n)][gfm_pkg::role4(n)] |= lvl[n];
        end
        gfm_pkg::FN_UART: begin
          next_st.uart_in[gfm_pkg::uart_unit(n)][gfm_pkg::role4(n)] |=
            lvl[n];
        end
        gfm_pkg::FN_I2C: begin
          next_st.i2c_in[gfm_pkg::i2c_unit(n)][n & 1] |= lvl[n];
        end
        gfm_pkg::FN_PWM: begin
          if ((n & 1) == 1) begin
            next_st.pwm_b_in[gfm_pkg::pwm_slice(n)] |= lvl[n];
          end
        end
        gfm_pkg::FN_CLOCK: begin
          if (n == gfm_pkg::CLKIN0_PIN) begin
            next_st.clk_in[0] = lvl[n];
          end else if (n == gfm_pkg::CLKIN1_PIN) begin
            next_st.clk_in[1] = lvl[n];
          end
        end
        gfm_pkg::FN_USB: begin
          if (gfm_pkg::usb_sel(n) == gfm_pkg::USB_OVCUR_SEL) begin
            next_st.usb_ovcur |= lvl[n];
          end else if (gfm_pkg::usb_sel(n) == gfm_pkg::USB_VBUS_DET_SEL) begin
            next_st.usb_vbus_det |= lvl[n];
          end
        end
        default: begin
        end
      endcase
    end
    for (int f = 0; f < gfm_pkg::FLASH_PINS; f++) begin
      if (function_select_field_flash[f] == gfm_pkg::FN_FLASH) begin
        next_st.flash_in[f] = lvl[gfm_pkg::FLASH_BASE + f];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign pad_out = st.pad_out;
  assign pad_oe = st.pad_oe;
  assign soft_io_in = st.soft_io_in;
  assign prog_in = st.prog_in;
  assign spi_in = st.spi_in;
  assign uart_in = st.uart_in;
  assign i2c_in = st.i2c_in;
  assign pwm_b_in = st.pwm_b_in;
  assign external_clock_input = st.clk_in;
  assign usb_overcurrent_detect = st.usb_ovcur;
  assign usb_vbus_detect = st.usb_vbus_det;
  assign flash_execute_in_place_in = st.flash_in;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_unmapped_undriven: assert property (
    (function_select_field_user[0] == gfm_pkg::FN_FLASH &&
     oe_override[0] == gfm_pkg::OVR_NORMAL) |=> !pad_oe[0])
    else $error("unmapped select drove pin 0");
  a_soft_io_drive: assert property (
    (function_select_field_user[3] == gfm_pkg::FN_SOFT_IO &&
     out_override[3] == gfm_pkg::OVR_NORMAL &&
     oe_override[3] == gfm_pkg::OVR_NORMAL) |=>
    (pad_out[3] == $past(soft_io_out[3]) &&
     pad_oe[3] == $past(soft_io_oe[3])))
    else $error("software io not on pin 3");
  a_soft_io_sees: assert property (
    ($stable(pad_in[7]) && in_override[7] == gfm_pkg::OVR_NORMAL)[*6]
    |-> soft_io_in[7] == pad_in[7])
    else $error("software io input lost on pin 7");
  a_prog_sees: assert property (
    ($stable(pad_in[12]) && in_override[12] == gfm_pkg::OVR_INVERT)[*6]
    |-> prog_in[12] != pad_in[12])
    else $error("program block input wrong on pin 12");
  a_spi_route: assert property (
    (function_select_field_user[9] == gfm_pkg::FN_SPI &&
     out_override[9] == gfm_pkg::OVR_NORMAL) |=>
    pad_out[9] == $past(spi_out[1][1]))
    else $error("spi unit 1 csn not on pin 9");
  a_uart_route: assert property (
    (function_select_field_user[20] == gfm_pkg::FN_UART &&
     out_override[20] == gfm_pkg::OVR_NORMAL) |=>
    pad_out[20] == $past(uart_out[1][0]))
    else $error("uart unit 1 tx not on pin 20");
  a_i2c_route: assert property (
    (function_select_field_user[2] == gfm_pkg::FN_I2C &&
     oe_override[2] == gfm_pkg::OVR_NORMAL) |=>
    pad_oe[2] == $past(i2c_oe[1][0]))
    else $error("i2c unit 1 sda not on pin 2");
  a_pwm_route: assert property (
    (function_select_field_user[25] == gfm_pkg::FN_PWM &&
     out_override[25] == gfm_pkg::OVR_NORMAL) |=>
    pad_out[25] == $past(pwm_out[4][1]))
    else $error("pwm slice 4 b not on pin 25");
  a_clock_out: assert property (
    (function_select_field_user[24] == gfm_pkg::FN_CLOCK &&
     oe_override[24] == gfm_pkg::OVR_NORMAL) |=> pad_oe[24])
    else $error("clock output 2 not driven on pin 24");
  a_usb_enable: assert property (
    (function_select_field_user[2] == gfm_pkg::FN_USB &&
     out_override[2] == gfm_pkg::OVR_NORMAL) |=>
    pad_out[2] == $past(usb_vbus_enable))
    else $error("vbus enable not on pin 2");
  a_flash_route: assert property (
    (function_select_field_flash[0] == gfm_pkg::FN_FLASH &&
     out_override[30] == gfm_pkg::OVR_NORMAL) |=>
    pad_out[30] == $past(flash_execute_in_place_out[0]))
    else $error("flash clock not on flash pin 0");
  a_force_high: assert property (
    out_override[5] == gfm_pkg::OVR_HIGH |=> pad_out[5])
    else $error("forced high output not high");
  a_input_or: assert property (
    (function_select_field_user[1] == gfm_pkg::FN_UART && lvl[1]) |=>
    uart_in[0][1])
    else $error("uart 0 rx misses pin 1");

  c_spi_pin: cover property (
    function_select_field_user[9] == gfm_pkg::FN_SPI ##1 pad_oe[9]);
  c_two_pins_or: cover property (
    function_select_field_user[1] == gfm_pkg::FN_UART &&
    function_select_field_user[13] == gfm_pkg::FN_UART ##1 uart_in[0][1]);
  c_pwm_input: cover property (pwm_b_in[0]);
  c_flash_soft: cover property (
    function_select_field_flash[2] == gfm_pkg::FN_SOFT_IO ##1 pad_oe[32]);

endmodule : gfm_mux

// ### tb/gfm_pins.sv
`timescale 1ns/1ns
module gfm_pins (
  // Pad side of the mux
  input wire logic [35:0] pad_out,
  input wire logic [35:0] pad_oe,
  // Levels that the board applies
  input wire logic [35:0] ext_level,
  // Level seen by the pad input buffers
  output logic [35:0] pad_in
);
  // The board drives a pad only while the mux has released it, so there
  // is never contention; a board level of zero stands for the pull-down.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : gfm_pins

// ### tb/tb_gfm_mux.sv
`timescale 1ns/1ns
module tb_gfm_mux;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [35:0] pad_in, pad_out, pad_oe, ext_level;
  logic [29:0][4:0] fs_user;
  logic [5:0][4:0] fs_flash;
  logic [35:0][1:0] out_ovr, oe_ovr, in_ovr;
  logic [35:0] sio_out, sio_oe, sio_in;
  logic [29:0] pa_out, pa_oe, pb_out, pb_oe, prog_in;
  logic [1:0][3:0] spi_out, spi_oe, spi_in, uart_out, uart_oe, uart_in;
  logic [1:0][1:0] i2c_out, i2c_oe, i2c_in;
  logic [7:0][1:0] pwm_out, pwm_oe;
  logic [7:0] pwm_b_in;
  logic [3:0] gclk_out;
  logic [1:0] ext_clk_in;
  logic ovc, vbus_det, vbus_en;
  logic [5:0] fx_out, fx_oe, fx_in;
  logic [31:0] agg;
  int errors = 0;
  int samples_checked = 0;
  // Output-only roles of serial units are left out of the input compare.
  localparam logic [31:0] IN_MASK = 32'hFFFF6611;

  always #2 clk = ~clk;
  assign agg = {vbus_det, ovc, ext_clk_in, pwm_b_in, i2c_in, uart_in, spi_in};

  gfm_mux gfm_mux_i (.clk(clk), .srst(srst), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe),
    .function_select_field_user(fs_user),
    .function_select_field_flash(fs_flash), .out_override(out_ovr),
    .oe_override(oe_ovr), .in_override(in_ovr), .soft_io_out(sio_out),
    .soft_io_oe(sio_oe), .soft_io_in(sio_in), .prog_a_out(pa_out),
    .prog_a_oe(pa_oe), .prog_b_out(pb_out), .prog_b_oe(pb_oe),
    .prog_in(prog_in), .spi_out(spi_out), .spi_oe(spi_oe), .spi_in(spi_in),
    .uart_out(uart_out), .uart_oe(uart_oe), .uart_in(uart_in),
    .i2c_out(i2c_out), .i2c_oe(i2c_oe), .i2c_in(i2c_in),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .pwm_b_in(pwm_b_in),
    .general_clock_output(gclk_out), .external_clock_input(ext_clk_in),
    .usb_overcurrent_detect(ovc), .usb_vbus_detect(vbus_det),
    .usb_vbus_enable(vbus_en), .flash_execute_in_place_out(fx_out),
    .flash_execute_in_place_oe(fx_oe), .flash_execute_in_place_in(fx_in));

  gfm_pins gfm_pins_i (.pad_out(pad_out), .pad_oe(pad_oe),
    .ext_level(ext_level), .pad_in(pad_in));

  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic clear_src(input logic v);
    sio_out = {36{v}};
    sio_oe = '0;
    pa_out = {30{v}};
    pb_out = {30{v}};
    pa_oe = '0;
    pb_oe = '0;
    spi_out = {8{v}};
    uart_out = {8{v}};
    i2c_out = {4{v}};
    pwm_out = {16{v}};
    spi_oe = '0;
    uart_oe = '0;
    i2c_oe = '0;
    pwm_oe = '0;
    gclk_out = {4{v}};
    vbus_en = v;
    fx_out = {6{v}};
    fx_oe = '0;
  endtask : clear_src

  function automatic logic ov(input logic lv, input int m);
    case (m)
      1: return ~lv;
      2: return 1'b0;
      3: return 1'b1;
      default: return lv;
    endcase
  endfunction : ov

  // Position in agg of the peripheral input fed by pin n under function f.
  function automatic int in_idx(input int n, input int f);
    int u;
    u = ((n % 16) >= 4 && (n % 16) < 12) ? 1 : 0;
    case (f)
      1: return (n % 4 == 0) ? ((n / 8) % 2) * 4 : -1;
      2: return (n % 4 == 1 || n % 4 == 2) ? 8 + u * 4 + n % 4 : -1;
      3: return 16 + ((n % 4 >= 2) ? 2 : 0) + n % 2;
      4: return (n % 2 == 1) ? 20 + (n / 2) % 8 : -1;
      8: return (n == 20) ? 28 : (n == 22) ? 29 : -1;
      9: return (n % 3 == 2) ? -1 : 30 + n % 3;
      default: return -1;
    endcase
  endfunction : in_idx

  // Drives v on the source that pin n must follow under f, ~v elsewhere.
  task automatic route_out(input int n, input int f, input logic v,
                           output bit ok);
    int u;
    int r;
    clear_src(~v);
    ok = 1'b1;
    r = n % 4;
    case (f)
      1: if (r == 0) ok = 1'b0; else begin
        u = (n / 8) % 2;
        spi_out[u][r] = v;
        spi_oe[u][r] = 1'b1;
      end
      2: if (r == 1 || r == 2) ok = 1'b0; else begin
        u = ((n % 16) >= 4 && (n % 16) < 12) ? 1 : 0;
        uart_out[u][r] = v;
        uart_oe[u][r] = 1'b1;
      end
      3: begin
        u = (r >= 2) ? 1 : 0;
        i2c_out[u][n % 2] = v;
        i2c_oe[u][n % 2] = 1'b1;
      end
      4: begin
        pwm_out[(n / 2) % 8][n % 2] = v;
        pwm_oe[(n / 2) % 8][n % 2] = 1'b1;
      end
      5: begin
        sio_out[n] = v;
        sio_oe[n] = 1'b1;
      end
      6: begin
        pa_out[n] = v;
        pa_oe[n] = 1'b1;
      end
      7: begin
        pb_out[n] = v;
        pb_oe[n] = 1'b1;
      end
      8: case (n)
        21: gclk_out[0] = v;
        23: gclk_out[1] = v;
        24: gclk_out[2] = v;
        25: gclk_out[3] = v;
        default: ok = 1'b0;
      endcase
      9: if (n % 3 == 2) vbus_en = v; else ok = 1'b0;
      default: ok = 1'b0;
    endcase
  endtask : route_out

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    bit ok;
    int idx;
    logic [35:0] exp_in;
    fs_user = '0;
    fs_flash = '0;
    out_ovr = '0;
    oe_ovr = '0;
    in_ovr = '0;
    ext_level = '0;
    clear_src(1'b0);
    tick(8);
    chk(pad_oe, 36'h0);
    chk(sio_in, 36'h0);
    srst = 1'b0;
    for (int n = 0; n < 30; n++) begin
      for (int f = 1; f < 10; f++) begin
        for (int vi = 0; vi < 2; vi++) begin
          fs_user = '0;
          fs_user[n] = 5'(f);
          route_out(n, f, vi[0], ok);
          if (ok) begin
            tick(1);
            chk(36'(pad_out[n]), 36'(vi[0]));
            chk(pad_oe, 36'h1 << n);
          end
        end
      end
    end
    // Clock and USB outputs drive their pads high, matching the board.
    clear_src(1'b0);
    gclk_out = '1;
    vbus_en = 1'b1;
    for (int n = 0; n < 30; n++) begin
      for (int f = 1; f < 10; f++) begin
        fs_user = '0;
        fs_user[n] = 5'(f);
        ext_level = 36'h1 << n;
        tick(6);
        idx = in_idx(n, f);
        exp_in = (idx < 0) ? 36'h0 : 36'(32'h1 << idx) & 36'(IN_MASK);
        chk(36'(agg & IN_MASK), exp_in);
        chk(sio_in, ext_level);
        chk(36'(prog_in), ext_level & 36'h3FFFFFFF);
      end
    end
    fs_user = '0;
    fs_user[1] = 5'h02;
    fs_user[13] = 5'h02;
    for (int k = 0; k < 4; k++) begin
      ext_level = (36'(k & 1) << 1) | (36'(k >> 1) << 13);
      tick(6);
      chk(36'(uart_in[0][1]), 36'(k != 0));
    end
    clear_src(1'b0);
    for (int m = 0; m < 4; m++) begin
      for (int lv = 0; lv < 2; lv++) begin
        fs_user = '0;
        fs_user[3] = 5'h05;
        fs_user[4] = 5'h05;
        sio_out[3] = lv[0];
        sio_oe[3] = 1'b1;
        sio_out[4] = 1'b1;
        sio_oe[4] = lv[0];
        ext_level = 36'(lv) << 7;
        out_ovr[3] = 2'(m);
        out_ovr[5] = 2'(m);
        oe_ovr[4] = 2'(m);
        in_ovr[7] = 2'(m);
        in_ovr[12] = 2'(m);
        tick(1);
        chk(36'(pad_out[3]), 36'(ov(lv[0], m)));
        chk(36'(pad_out[5]), 36'(ov(1'b0, m)));
        chk(36'(pad_oe[4]), 36'(ov(lv[0], m)));
        tick(5);
        chk(36'(sio_in[7]), 36'(ov(lv[0], m)));
        chk(36'(prog_in[12]), 36'(ov(1'b0, m)));
      end
    end
    // ***************************************************************
    // Flash bank
    // ***************************************************************
    out_ovr = '0;
    oe_ovr = '0;
    in_ovr = '0;
    fs_user = '0;
    ext_level = '0;
    clear_src(1'b0);
    fx_out = 6'h2D;
    fx_oe = 6'h3F;
    tick(1);
    chk(36'(pad_out[35:30]), 36'h2D);
    chk(36'(pad_oe[35:30]), 36'h3F);
    tick(5);
    chk(36'(fx_in), 36'h2D);
    chk(36'(sio_in[35:30]), 36'h2D);
    fs_flash = {6{5'h05}};
    sio_out[35:30] = 6'h1A;
    sio_oe[35:30] = 6'h3F;
    tick(1);
    chk(36'(pad_out[35:30]), 36'h1A);
    tick(5);
    chk(36'(fx_in), 36'h0);
    chk(36'(sio_in[35:30]), 36'h1A);
    fs_flash = {6{5'h01}};
    tick(1);
    chk(36'(pad_oe[35:30]), 36'h0);
    // Drive the flash pads again so that the mid-run reset has work to do.
    fs_flash = {6{5'h05}};
    tick(6);
    srst = 1'b1;
    tick(1);
    chk(pad_oe, 36'h0);
    chk(sio_in, 36'h0);
    srst = 1'b0;
    tick(1);
    chk(36'(pad_oe[35:30]), 36'h3F);
    chk(36'(pad_out[35:30]), 36'h1A);
    chk(36'(sio_in[35:30]), 36'h0);
    close_out();
  end
endmodule : tb_gfm_mux
